// ==== logic/ppos_port_power.sv ====
`include "ppos_params.svh"

// What this block does
// - two low groupings within window flag overcurrent
// - window register resets to 20 ms
// - ignore pin during lockout after power on
// - lockout register resets to 10 ms
// - power off drives pin low, pull-up off
// - power on releases driver, enables pull-up
// - low pin while powered means overcurrent
// - split accepted only on ports 3, 4
// - split configured before normal hub operation
// - split adds separate superspeed power gpio pin
// - split power pin is output only
// - port 3 select picks gpio option
// - port 4 select picks gpio option
// - enable bits 5, 6; reset zero
// - no valid link for timeout toggles pin
// - link timer restarts after every timeout
// - single pulse width 0 to 15 ms
// - double detection only while powered and sampled
// - link timeout code table, default 1 s
// - toggle low 350 ms plus 10 ms steps
module ppos_port_power
  import ppos_pkg::*;
#(
  parameter int NUM_PORTS = 4,
  parameter int TICK_CYCLES = `PPOS_TICK_NS / `PPOS_CLK_NS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hubRunning,
  input wire logic cfgWrite,
  input wire logic [15:0] cfgAddr,
  input wire logic [7:0] cfgWrData,
  output logic [7:0] cfgRdData,
  input wire logic [NUM_PORTS-1:0] portPowerOn,
  input wire logic [NUM_PORTS-1:0] portPowerSensePinIn,
  output logic [NUM_PORTS-1:0] portPowerSensePinOut,
  output logic [NUM_PORTS-1:0] portPowerSensePinOe,
  output logic [NUM_PORTS-1:0] portPullupEn,
  output logic [NUM_PORTS-1:0] overcurrentEvent,
  output logic [NUM_PORTS-1:0] overcurrentStatus,
  input wire logic [1:0] superspeedLinkValid,
  output logic splitPinPort3OptA,
  output logic splitPinPort3OptAOe,
  output logic splitPinPort3OptB,
  output logic splitPinPort3OptBOe,
  output logic splitPinPort4OptA,
  output logic splitPinPort4OptAOe,
  output logic splitPinPort4OptB,
  output logic splitPinPort4OptBOe
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    logic [TW-1:0] tickCnt;
    logic tick;
    ppos_regs_t regs;
    logic [7:0] rdData;
    ppos_oc_t [NUM_PORTS-1:0] oc;
    ppos_split_t [1:0] spl;
  } ppos_state_t;

  ppos_state_t state_reg;
  ppos_state_t state_next;

  function automatic logic [11:0] timeoutMs(input logic [2:0] code);
    unique case (code)
      3'h1: return `PPOS_TO_MS_1;
      3'h2: return `PPOS_TO_MS_2;
      3'h3: return `PPOS_TO_MS_3;
      3'h4: return `PPOS_TO_MS_4;
      3'h5: return `PPOS_TO_MS_5;
      3'h6: return `PPOS_TO_MS_6;
      default: return 12'h000; // reserved code behaves as never toggle
    endcase
  endfunction

  always_comb begin
    logic low;
    logic sensing;
    logic detect;
    logic active;
    logic [11:0] lim;
    logic [11:0] togMs;
    low = 1'b0;
    sensing = 1'b0;
    detect = 1'b0;
    active = 1'b0;
    lim = timeoutMs(state_reg.regs.timeout);
    togMs = `PPOS_TOGGLE_BASE_MS + `PPOS_TOGGLE_STEP_MS * {4'h0, state_reg.regs.toggle};
    state_next = state_reg;
    // common millisecond enable
    if (state_reg.tickCnt == TW'(TICK_CYCLES - 1)) begin
      state_next.tickCnt = '0;
      state_next.tick = 1'b1;
    end else begin
      state_next.tickCnt = state_reg.tickCnt + 1'b1;
      state_next.tick = 1'b0;
    end
    if (cfgWrite) begin
      unique case (cfgAddr)
        `PPOS_ADDR_LOCKOUT: state_next.regs.lockout = cfgWrData;
        `PPOS_ADDR_WINDOW: state_next.regs.window = cfgWrData;
        `PPOS_ADDR_MINWIDTH: state_next.regs.minWidth = cfgWrData[3:0];
        `PPOS_ADDR_SPLITEN: begin
          // only the port 3 and 4 bits exist; no other port can split
          if (!hubRunning) begin
            state_next.regs.splitEn = {cfgWrData[`PPOS_BIT_SPLIT4],
                                       cfgWrData[`PPOS_BIT_SPLIT3]};
          end
        end
        `PPOS_ADDR_SEL3: if (!hubRunning) state_next.regs.sel3 = cfgWrData;
        `PPOS_ADDR_SEL4: if (!hubRunning) state_next.regs.sel4 = cfgWrData;
        `PPOS_ADDR_TIMEOUT: state_next.regs.timeout = cfgWrData[2:0];
        `PPOS_ADDR_TOGGLE: state_next.regs.toggle = cfgWrData;
        default: ;
      endcase
    end
    unique case (cfgAddr)
      `PPOS_ADDR_LOCKOUT: state_next.rdData = state_reg.regs.lockout;
      `PPOS_ADDR_WINDOW: state_next.rdData = state_reg.regs.window;
      `PPOS_ADDR_MINWIDTH: state_next.rdData = {4'h0, state_reg.regs.minWidth};
      `PPOS_ADDR_SPLITEN: state_next.rdData = {1'b0, state_reg.regs.splitEn, 5'h00};
      `PPOS_ADDR_SEL3: state_next.rdData = state_reg.regs.sel3;
      `PPOS_ADDR_SEL4: state_next.rdData = state_reg.regs.sel4;
      `PPOS_ADDR_TIMEOUT: state_next.rdData = {5'h00, state_reg.regs.timeout};
      `PPOS_ADDR_TOGGLE: state_next.rdData = state_reg.regs.toggle;
      default: state_next.rdData = 8'h00;
    endcase
    for (int p = 0; p < NUM_PORTS; p++) begin
      state_next.oc[p].ocEvent = 1'b0;
      state_next.oc[p].pwr = portPowerOn[p];
      if (!state_reg.oc[p].pwr) state_next.oc[p].ocStatus = 1'b0;
      // a zero lockout value would leave no settling time at all
      if (portPowerOn[p] && !state_reg.oc[p].pwr) begin
        state_next.oc[p].lockCnt = state_reg.regs.lockout;
      end else if (state_reg.tick && state_reg.oc[p].lockCnt != 8'h00) begin
        state_next.oc[p].lockCnt = state_reg.oc[p].lockCnt - 8'h01;
      end
      sensing = state_reg.oc[p].pwr && state_reg.oc[p].lockCnt == 8'h00;
      if (!sensing) begin
        state_next.oc[p].lowMs = 4'h0;
        state_next.oc[p].winCnt = 8'h00;
        state_next.oc[p].prevLow = 1'b0;
      end else begin
        low = !portPowerSensePinIn[p];
        detect = 1'b0;
        state_next.oc[p].prevLow = low;
        if (low) begin
          if (state_reg.oc[p].lowMs >= state_reg.regs.minWidth) begin
            detect = 1'b1;
          end else if (state_reg.tick) begin
            state_next.oc[p].lowMs = state_reg.oc[p].lowMs + 4'h1;
          end
        end else begin
          state_next.oc[p].lowMs = 4'h0;
        end
        if (state_reg.tick && state_reg.oc[p].winCnt != 8'h00) begin
          state_next.oc[p].winCnt = state_reg.oc[p].winCnt - 8'h01;
        end
        if (low && !state_reg.oc[p].prevLow) begin
          if (state_reg.oc[p].winCnt != 8'h00) begin
            detect = 1'b1;
          end else begin
            state_next.oc[p].winCnt = state_reg.regs.window;
          end
        end
        if (detect && !state_reg.oc[p].ocStatus) begin
          state_next.oc[p].ocEvent = 1'b1;
          state_next.oc[p].ocStatus = 1'b1;
        end
      end
    end
    for (int j = 0; j < 2; j++) begin
      active = hubRunning && state_reg.regs.splitEn[j];
      state_next.spl[j].drive = active;
      unique case (state_reg.spl[j].st)
        PPOS_SPL_IDLE: begin
          state_next.spl[j].cnt = 12'h000;
          if (active && lim != 12'h000) state_next.spl[j].st = PPOS_SPL_RUN;
        end
        PPOS_SPL_RUN: begin
          if (!active || lim == 12'h000) begin
            state_next.spl[j].st = PPOS_SPL_IDLE;
            state_next.spl[j].cnt = 12'h000;
          end else if (superspeedLinkValid[j]) begin
            state_next.spl[j].cnt = 12'h000;
          end else if (state_reg.tick) begin
            if (state_reg.spl[j].cnt + 12'h001 >= lim) begin
              state_next.spl[j].st = PPOS_SPL_TOGGLE;
              state_next.spl[j].cnt = 12'h000;
            end else begin
              state_next.spl[j].cnt = state_reg.spl[j].cnt + 12'h001;
            end
          end
        end
        PPOS_SPL_TOGGLE: begin
          if (!active) begin
            state_next.spl[j].st = PPOS_SPL_IDLE;
            state_next.spl[j].cnt = 12'h000;
          end else if (state_reg.tick) begin
            if (state_reg.spl[j].cnt + 12'h001 >= togMs) begin
              state_next.spl[j].st = PPOS_SPL_RUN;
              state_next.spl[j].cnt = 12'h000;
            end else begin
              state_next.spl[j].cnt = state_reg.spl[j].cnt + 12'h001;
            end
          end
        end
        default: begin
          state_next.spl[j].st = PPOS_SPL_IDLE;
          state_next.spl[j].cnt = 12'h000;
        end
      endcase
      // superspeed power follows port power except while toggled off
      state_next.spl[j].pinLevel = active && portPowerOn[2 + j] &&
                                   state_next.spl[j].st != PPOS_SPL_TOGGLE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.regs.lockout <= `PPOS_RST_LOCKOUT;
      state_reg.regs.window <= `PPOS_RST_WINDOW;
      state_reg.regs.minWidth <= `PPOS_RST_MINWIDTH;
      state_reg.regs.splitEn <= `PPOS_RST_SPLITEN;
      state_reg.regs.sel3 <= `PPOS_RST_SEL;
      state_reg.regs.sel4 <= `PPOS_RST_SEL;
      state_reg.regs.timeout <= `PPOS_RST_TIMEOUT;
      state_reg.regs.toggle <= `PPOS_RST_TOGGLE;
      for (int j = 0; j < 2; j++) state_reg.spl[j].st <= PPOS_SPL_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cfgRdData = state_reg.rdData;
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_pin
    assign portPowerSensePinOut[p] = 1'b0;
    assign portPowerSensePinOe[p] = !state_reg.oc[p].pwr;
    assign portPullupEn[p] = state_reg.oc[p].pwr;
    assign overcurrentEvent[p] = state_reg.oc[p].ocEvent;
    assign overcurrentStatus[p] = state_reg.oc[p].ocStatus;
  end
  // split pins have no input path, so no sensing there
  assign splitPinPort3OptA = state_reg.spl[0].pinLevel;
  assign splitPinPort3OptB = state_reg.spl[0].pinLevel;
  assign splitPinPort4OptA = state_reg.spl[1].pinLevel;
  assign splitPinPort4OptB = state_reg.spl[1].pinLevel;
  assign splitPinPort3OptAOe = state_reg.spl[0].drive && state_reg.regs.sel3 == `PPOS_SEL3_A;
  assign splitPinPort3OptBOe = state_reg.spl[0].drive && state_reg.regs.sel3 == `PPOS_SEL3_B;
  assign splitPinPort4OptAOe = state_reg.spl[1].drive && state_reg.regs.sel4 == `PPOS_SEL4_A;
  assign splitPinPort4OptBOe = state_reg.spl[1].drive && state_reg.regs.sel4 == `PPOS_SEL4_B;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_window_default: assert property (disable iff (1'b0) rst |=> state_reg.regs.window == 8'h14)
    else $error("window register not 20 ms after reset");
  a_lockout_default: assert property (disable iff (1'b0) rst |=> state_reg.regs.lockout == 8'h0a)
    else $error("lockout register not 10 ms after reset");
  a_spliten_default: assert property (disable iff (1'b0) rst |=> state_reg.regs.splitEn == 2'h0)
    else $error("split enable not clear after reset");
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_chk
    a_off_drive: assert property (!portPowerOn[p] |=> portPowerSensePinOe[p] && !portPullupEn[p])
      else $error("unpowered port pin not driven low");
    a_on_release: assert property (portPowerOn[p] |=> !portPowerSensePinOe[p] && portPullupEn[p])
      else $error("powered port pin not released");
    a_lockout_load: assert property (portPowerOn[p] && !state_reg.oc[p].pwr
        |=> state_reg.oc[p].lockCnt == $past(state_reg.regs.lockout))
      else $error("lockout not loaded at power on");
    a_lockout_quiet: assert property ($rose(state_reg.oc[p].pwr) |-> (!overcurrentEvent[p]) [*8])
      else $error("overcurrent reported during lockout");
    a_double_pulse: assert property (state_reg.oc[p].pwr && state_reg.oc[p].lockCnt == 8'h00 &&
        !portPowerSensePinIn[p] && !state_reg.oc[p].prevLow && state_reg.oc[p].winCnt != 8'h00 &&
        !state_reg.oc[p].ocStatus |=> overcurrentEvent[p] && overcurrentStatus[p])
      else $error("second low grouping in window not flagged");
    c_overcurrent: cover property (overcurrentEvent[p]);
  end
  for (genvar j = 0; j < 2; j++) begin : g_spl
    a_link_toggle: assert property (state_reg.spl[j].st == PPOS_SPL_RUN && state_reg.tick &&
        hubRunning && state_reg.regs.splitEn[j] && !superspeedLinkValid[j] &&
        timeoutMs(state_reg.regs.timeout) != 12'h000 &&
        state_reg.spl[j].cnt + 12'h001 >= timeoutMs(state_reg.regs.timeout)
        |=> state_reg.spl[j].st == PPOS_SPL_TOGGLE ##1 !state_reg.spl[j].pinLevel)
      else $error("link timeout did not toggle split pin");
    a_toggle_restart: assert property (state_reg.spl[j].st == PPOS_SPL_TOGGLE ##1
        state_reg.spl[j].st == PPOS_SPL_RUN |-> state_reg.spl[j].cnt == 12'h000)
      else $error("link counter not restarted after toggle");
    a_link_clear: assert property (state_reg.spl[j].st == PPOS_SPL_RUN && superspeedLinkValid[j]
        |=> state_reg.spl[j].cnt == 12'h000)
      else $error("valid link did not clear counter");
    c_toggle: cover property (state_reg.spl[j].st == PPOS_SPL_TOGGLE ##1
                              state_reg.spl[j].st == PPOS_SPL_TOGGLE);
    c_toggle_done: cover property (state_reg.spl[j].st == PPOS_SPL_TOGGLE ##1
                                   state_reg.spl[j].st == PPOS_SPL_RUN);
  end
  c_lockout_end: cover property (state_reg.oc[0].lockCnt == 8'h01 ##1 state_reg.oc[0].lockCnt == 8'h00);
endmodule

// ==== logic/ppos_params.svh ====
`ifndef PPOS_PARAMS_SVH
`define PPOS_PARAMS_SVH
`define PPOS_CLK_NS 10
`define PPOS_TICK_NS 1000000
`define PPOS_ADDR_LOCKOUT 16'h30e1
`define PPOS_ADDR_MINWIDTH 16'h30ea
`define PPOS_ADDR_WINDOW 16'h30eb
`define PPOS_ADDR_SPLITEN 16'h3c48
`define PPOS_ADDR_SEL3 16'h416e
`define PPOS_ADDR_SEL4 16'h416f
`define PPOS_ADDR_TIMEOUT 16'h4171
`define PPOS_ADDR_TOGGLE 16'h4176
`define PPOS_RST_LOCKOUT 8'h0a
`define PPOS_RST_WINDOW 8'h14
`define PPOS_RST_MINWIDTH 4'h5
`define PPOS_RST_SPLITEN 2'h0
`define PPOS_RST_SEL 8'h00
`define PPOS_RST_TIMEOUT 3'h5
`define PPOS_RST_TOGGLE 8'h05
`define PPOS_BIT_SPLIT3 5
`define PPOS_BIT_SPLIT4 6
`define PPOS_SEL3_A 8'h42
`define PPOS_SEL3_B 8'h05
`define PPOS_SEL4_A 8'h06
`define PPOS_SEL4_B 8'h04
`define PPOS_TO_MS_1 12'h064
`define PPOS_TO_MS_2 12'h0fa
`define PPOS_TO_MS_3 12'h1f4
`define PPOS_TO_MS_4 12'h2ee
`define PPOS_TO_MS_5 12'h3e8
`define PPOS_TO_MS_6 12'h7d0
`define PPOS_TOGGLE_BASE_MS 12'h15e
`define PPOS_TOGGLE_STEP_MS 12'h00a
`endif

// ==== logic/ppos_pkg.sv ====
package ppos_pkg;
  typedef enum logic [2:0] {
    PPOS_SPL_IDLE = 3'b001,
    PPOS_SPL_RUN = 3'b010,
    PPOS_SPL_TOGGLE = 3'b100
  } ppos_spl_e_t;

  typedef struct packed {
    logic pwr;
    logic [7:0] lockCnt;
    logic [3:0] lowMs;
    logic [7:0] winCnt;
    logic prevLow;
    logic ocEvent;
    logic ocStatus;
  } ppos_oc_t;

  typedef struct packed {
    ppos_spl_e_t st;
    logic [11:0] cnt;
    logic drive;
    logic pinLevel;
  } ppos_split_t;

  typedef struct packed {
    logic [7:0] lockout;
    logic [7:0] window;
    logic [3:0] minWidth;
    logic [1:0] splitEn;
    logic [7:0] sel3;
    logic [7:0] sel4;
    logic [2:0] timeout;
    logic [7:0] toggle;
  } ppos_regs_t;
endpackage

// ==== tb/ppos_far_side.sv ====
module ppos_far_side (
  input wire logic clk,
  input wire logic [3:0] senseOe,
  input wire logic [3:0] pullupEn,
  input wire logic [3:0] faultLow,
  input wire logic [1:0] splitPower,
  input wire logic [1:0] linkReady,
  output logic [3:0] senseIn,
  output logic [1:0] linkValid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] flip = 4'h5;
  logic [4:0] upCnt [2] = '{5'h00, 5'h00};
  initial linkValid = 2'h0;
  // plain always here: the initial above also writes linkValid
  // undriven, unpulled pin floats: toggle so a stale level is never trusted
  always_ff @(posedge clk) flip <= ~flip;
  // switch flag or blown fuse pulls the pin low through the diode
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      senseIn[i] = senseOe[i] ? 1'b0 : (pullupEn[i] ? ~faultLow[i] : flip[i]);
    end
  end
  // embedded device trains its link some time after power comes up
  always @(posedge clk) begin
    for (int j = 0; j < 2; j++) begin
      if (!splitPower[j]) begin
        upCnt[j] <= 5'h00;
      end else if (upCnt[j] != 5'h1f) begin
        upCnt[j] <= upCnt[j] + 5'h01;
      end
      linkValid[j] <= linkReady[j] && splitPower[j] && (upCnt[j] >= 5'h14);
    end
  end
endmodule

// ==== tb/tb_ppos_port_power.sv ====
module tb_ppos_port_power;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, hubRunning = 1'b0, cfgWrite = 1'b0;
  logic [15:0] cfgAddr = 16'h0000;
  logic [7:0] cfgWrData = 8'h00, cfgRdData;
  logic [3:0] portPowerOn = 4'h0, senseIn, senseOut, senseOe, pullupEn, ocEvent, ocStatus;
  logic [3:0] faultLow = 4'h0, evSeen = 4'h0;
  logic [1:0] linkValid, linkReady = 2'h0;
  logic p3a, p3aOe, p3b, p3bOe, p4a, p4aOe, p4b, p4bOe, p4Low = 1'b0;
  int failures = 0, compares = 0, cycles = 0, t1, t2, t3;
  always #5 clk = ~clk;
  ppos_port_power #(.NUM_PORTS(4), .TICK_CYCLES(10)) uut (.clk(clk), .rst(rst),
    .hubRunning(hubRunning), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .portPowerOn(portPowerOn), .portPowerSensePinIn(senseIn),
    .portPowerSensePinOut(senseOut), .portPowerSensePinOe(senseOe), .portPullupEn(pullupEn),
    .overcurrentEvent(ocEvent), .overcurrentStatus(ocStatus), .superspeedLinkValid(linkValid),
    .splitPinPort3OptA(p3a), .splitPinPort3OptAOe(p3aOe), .splitPinPort3OptB(p3b),
    .splitPinPort3OptBOe(p3bOe), .splitPinPort4OptA(p4a), .splitPinPort4OptAOe(p4aOe),
    .splitPinPort4OptB(p4b), .splitPinPort4OptBOe(p4bOe));
  ppos_far_side far (.clk(clk), .senseOe(senseOe), .pullupEn(pullupEn), .faultLow(faultLow),
    .splitPower({p4b & p4bOe, p3a & p3aOe}), .linkReady(linkReady), .senseIn(senseIn),
    .linkValid(linkValid));
  always @(posedge clk) begin
    cycles++;
    evSeen <= evSeen | ocEvent;
    if (hubRunning && p4bOe === 1'b1 && p4b !== 1'b1) p4Low <= 1'b1;
    if (cycles == 15000) begin
      failures++;
      finish_test();
    end
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    cfgAddr <= a;
    cfgWrData <= d;
    cfgWrite <= 1'b1;
    @(posedge clk);
    cfgWrite <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    cfgAddr <= a;
    repeat (2) @(posedge clk);
    check({4'h0, cfgRdData}, {4'h0, exp});
  endtask
  task automatic pulse(input int p);
    @(posedge clk);
    faultLow[p] <= 1'b1;
    repeat (2) @(posedge clk);
    faultLow[p] <= 1'b0;
  endtask
  task automatic measure(input logic lvl, output int t);
    t = 0;
    while (p3a === lvl && t < 5000) begin
      @(posedge clk);
      t++;
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(16'h30e1, 8'h0a);
    rd(16'h30eb, 8'h14);
    rd(16'h3c48, 8'h00);
    rd(16'h30ea, 8'h05);
    rd(16'h4171, 8'h05);
    rd(16'h1234, 8'h00);
    check({8'h0, senseOe, pullupEn}, 12'h0f0);
    check({8'h0, senseOut}, 12'h000);
    $display("test reset done");
    // lockout kept nonzero, as software must zero width is legal
    wr(16'h30e1, 8'h03);
    wr(16'h30ea, 8'h00);
    faultLow[0] <= 1'b1;
    portPowerOn[0] <= 1'b1;
    repeat (3) @(posedge clk);
    check({10'h0, senseOe[0], pullupEn[0]}, 12'h001);
    repeat (12) @(posedge clk);
    check({11'h0, ocStatus[0]}, 12'h000);
    repeat (30) @(posedge clk);
    check({10'h0, ocStatus[0], evSeen[0]}, 12'h003);
    faultLow[0] <= 1'b0;
    portPowerOn[0] <= 1'b0;
    $display("test lockout done");
    wr(16'h30ea, 8'h05);
    wr(16'h30eb, 8'h05);
    rd(16'h30eb, 8'h05);
    portPowerOn[1:0] <= 2'b11;
    repeat (60) @(posedge clk);
    pulse(1);
    repeat (20) @(posedge clk);
    pulse(1);
    repeat (5) @(posedge clk);
    check({11'h0, ocStatus[1]}, 12'h001);
    pulse(0);
    repeat (80) @(posedge clk);
    pulse(0);
    repeat (5) @(posedge clk);
    check({11'h0, ocStatus[0]}, 12'h000);
    portPowerOn[1:0] <= 2'b00;
    $display("test double pulse done");
    wr(16'h416e, 8'h42);
    wr(16'h416f, 8'h04);
    wr(16'h3c48, 8'hff);
    wr(16'h4171, 8'h01);
    wr(16'h4176, 8'h00);
    rd(16'h3c48, 8'h60);
    linkReady <= 2'b10;
    portPowerOn[3:2] <= 2'b11;
    hubRunning <= 1'b1;
    wr(16'h3c48, 8'h00);
    rd(16'h3c48, 8'h60);
    check({8'h0, p3aOe, p3bOe, p4aOe, p4bOe}, 12'h009);
    check({10'h0, p3a, p4b}, 12'h003);
    measure(1'b1, t1);
    check(12'(t1 >= 980 && t1 <= 1010), 12'h001);
    measure(1'b0, t2);
    check(12'(t2 >= 3490 && t2 <= 3510), 12'h001);
    measure(1'b1, t3);
    check(12'(t3 >= 980 && t3 <= 1020), 12'h001);
    check({11'h0, p4Low}, 12'h000);
    $display("test split done");
    // back to configuration stage to reach the other two pin options
    hubRunning <= 1'b0;
    wr(16'h416e, 8'h05);
    check({8'h0, p3aOe, p3bOe, p4aOe, p4bOe}, 12'h000);
    wr(16'h416f, 8'h06);
    hubRunning <= 1'b1;
    repeat (2) @(posedge clk);
    check({8'h0, p3aOe, p3bOe, p4aOe, p4bOe}, 12'h006);
    check({10'h0, p3b, p4a}, 12'h003);
    $display("test select done");
    finish_test();
  end
endmodule
